// ==== logic/tsac_core.sv ====
// Alert flags, configuration and conversion sequencing of a digital temperature sensor,
// with the 3-wire serial link front end that reads and writes its registers.
// Assumes a converter on core_clk_i answering each conv_start_o with one conv_done_i,
// and limits and alert enables held elsewhere on the same clock.
//
// Functional notes
// - High flag sets crossing above or below hysteresis
// - High flag re-arms only below threshold minus hysteresis
// - Low flag sets crossing below or above hysteresis
// - Low flag re-arms only above threshold plus hysteresis
// - Ready flag set per result, cleared by temperature reads and single flag reads
// - Soft reset bit starts 0.5 ms reset, reads zero
// - Averaging bit makes every result eight-sample mean
// - Bit 5 selects interrupt or comparator alert
// - One-shot bit converts once then shuts down
// - Mode bit selects continuous or shutdown
// - Period select maps codes to eight intervals
// - Configuration resets to 0006h
// - Limit flags clear only on single non-incrementing read
// - Alert driven by enabled flags or live states
// - Result is 14-bit in bits 15:2
`timescale 1ns/1ps
`include "tsac_defs.svh"
module tsac_core #(
   parameter int unsigned UNIT_CYCLES = (`TSAC_CLK_HZ / 1000000) * `TSAC_UNIT_TIME_US
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   srst_i,
   input  wire logic                   spi_clk_i,
   input  wire logic                   spi_cs_n_i,
   input  wire logic                   spi_sio_i,
   output logic                        spi_sio_o,
   output logic                        spi_sio_oe_o,
   output logic                        conv_start_o,
   input  wire logic                   conv_done_i,
   input  wire logic [13:0]            conv_data_i,
   input  wire tsac_pkg::tsac_limits_s limits_i,
   input  wire tsac_pkg::tsac_alert_en_s alert_en_i,
   output logic                        alert_o,
   output logic                        soft_rst_busy_o
);

   localparam int unsigned SOFT_UNITS =
      (`TSAC_SOFT_RST_TIME_US + `TSAC_UNIT_TIME_US - 1) / `TSAC_UNIT_TIME_US;

   // Configuration word to stored fields; reserved and self-clearing bits fall away
   function automatic tsac_pkg::tsac_cfg_s cfg_from_word(input logic [15:0] w);
      tsac_pkg::tsac_cfg_s c;
      c.averaging_enable = w[`TSAC_CFG_AVG_BIT];
      c.comp_mode        = w[`TSAC_CFG_COMP_BIT];
      c.shutdown         = w[`TSAC_CFG_MODE_BIT];
      c.period_sel       = w[`TSAC_CFG_PER_MSB:`TSAC_CFG_PER_LSB];
      return c;
   endfunction : cfg_from_word

   // Conversion period in prescaler units
   function automatic logic [12:0] period_units(input logic [2:0] sel);
      int unsigned us;
      us = 0;
      unique case (sel)
         3'h0: us = `TSAC_PER0_US;
         3'h1: us = `TSAC_PER1_US;
         3'h2: us = `TSAC_PER2_US;
         3'h3: us = `TSAC_PER3_US;
         3'h4: us = `TSAC_PER4_US;
         3'h5: us = `TSAC_PER5_US;
         3'h6: us = `TSAC_PER6_US;
         3'h7: us = `TSAC_PER7_US;
      endcase
      return 13'(us / `TSAC_UNIT_TIME_US);
   endfunction : period_units

   logic [2:0]          pins_sync;
   logic                sclk_q;
   logic                sclk_rise;
   logic                sclk_fall;
   logic                cs_act;
   logic [3:0]          bit_cnt;
   logic                in_data;
   logic                rd_frame;
   logic                inc_frame;
   logic [7:0]          frame_addr;
   logic [15:0]         rx_shift;
   logic [15:0]         tx_shift;
   logic [15:0]         rx_next;
   logic [7:0]          next_addr;
   logic                word_done;
   logic                rd_load;
   logic                rd_inc;
   logic                wr_cfg;
   logic [15:0]         rd_word;
   logic                clr_flags;
   logic                clr_ready;
   logic                int_rst;
   logic [19:0]         pre_cnt;
   logic                unit_tick;
   logic [3:0]          soft_left;
   logic                soft_start;
   logic                os_trig;
   tsac_pkg::tsac_cfg_s cfg;
   tsac_pkg::tsac_seq_e seq;
   logic [12:0]         unit_cnt;
   logic                period_up;
   logic                meas_start;
   logic                oneshot_pend;
   logic [2:0]          samp_cnt;
   logic [16:0]         acc;
   logic [16:0]         sum_next;
   logic [13:0]         res_val;
   logic                res_done;
   logic [13:0]         temp_val;
   logic                hi_flag;
   logic                lo_flag;
   logic                rdy_flag;
   logic                hi_state;
   logic                lo_state;
   logic                next_hi_state;
   logic                next_lo_state;
   logic signed [16:0]  r_s;
   logic signed [16:0]  hi_s;
   logic signed [16:0]  lo_s;
   logic signed [16:0]  hi_rel_s;
   logic signed [16:0]  lo_rel_s;
   logic                lim_valid;

   // Link pins: clock, chip select (idle high) and data in
   tsac_sync2 #(.WIDTH(3), .RST_VAL(3'h2)) u_sync (
      .core_clk_i(core_clk_i),
      .srst_i    (srst_i),
      .async_i   ({spi_clk_i, spi_cs_n_i, spi_sio_i}),
      .sync_o    (pins_sync)
   );

   // Edge finder on the synchronised link clock
   always_ff @(posedge core_clk_i) begin
      if (srst_i) sclk_q <= 1'b0;
      else        sclk_q <= pins_sync[2];
   end
   assign sclk_rise = pins_sync[2] & ~sclk_q;
   assign sclk_fall = ~pins_sync[2] & sclk_q;
   assign cs_act    = ~pins_sync[1];

   // Frame decode: word address, read load and single-read detection
   always_comb begin
      rx_next   = {rx_shift[14:0], pins_sync[0]};
      word_done = cs_act & sclk_rise & (bit_cnt == 4'hF);
      if (!in_data)       next_addr = rx_next[7:0];
      else if (inc_frame) next_addr = frame_addr + 8'h01;
      else                next_addr = frame_addr;
      rd_inc    = in_data ? inc_frame : rx_next[`TSAC_CMD_INC_BIT];
      rd_load   = word_done & (in_data ? rd_frame : rx_next[`TSAC_CMD_READ_BIT]);
      wr_cfg    = word_done & in_data & ~rd_frame & (frame_addr == `TSAC_ADDR_CFG) & ~int_rst;
      clr_flags = rd_load & (next_addr == `TSAC_ADDR_FLAGS) & ~rd_inc;
      clr_ready = clr_flags | (rd_load & (next_addr == `TSAC_ADDR_TEMP));
   end

   // Read multiplexer; self-clearing and reserved bits stay zero
   always_comb begin
      rd_word = 16'h0000;
      unique case (next_addr)
         `TSAC_ADDR_TEMP: rd_word[15:`TSAC_TEMP_LSB] = temp_val;
         `TSAC_ADDR_FLAGS: begin
            rd_word[`TSAC_FLAG_HI_ST_BIT] = hi_state;
            rd_word[`TSAC_FLAG_LO_ST_BIT] = lo_state;
            rd_word[`TSAC_FLAG_HI_BIT]    = hi_flag;
            rd_word[`TSAC_FLAG_LO_BIT]    = lo_flag;
            rd_word[`TSAC_FLAG_RDY_BIT]   = rdy_flag;
         end
         `TSAC_ADDR_CFG: begin
            rd_word[`TSAC_CFG_AVG_BIT]                     = cfg.averaging_enable;
            rd_word[`TSAC_CFG_COMP_BIT]                    = cfg.comp_mode;
            rd_word[`TSAC_CFG_MODE_BIT]                    = cfg.shutdown;
            rd_word[`TSAC_CFG_PER_MSB:`TSAC_CFG_PER_LSB]   = cfg.period_sel;
         end
         default: rd_word = 16'h0000;
      endcase
   end

   // Link shift state; chip select high aborts and restarts the frame
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !cs_act) begin
         bit_cnt <= 4'h0;
         in_data <= 1'b0;
      end else if (sclk_rise) begin
         rx_shift <= rx_next;
         bit_cnt  <= bit_cnt + 4'h1;
         if (word_done) begin
            in_data    <= 1'b1;
            frame_addr <= next_addr;
            if (!in_data) begin
               rd_frame  <= rx_next[`TSAC_CMD_READ_BIT];
               inc_frame <= rx_next[`TSAC_CMD_INC_BIT];
            end
         end
      end
   end

   // Read data leaves on falling link clock edges, MSB first
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_shift     <= 16'h0000;
         spi_sio_o    <= 1'b0;
         spi_sio_oe_o <= 1'b0;
      end else begin
         spi_sio_oe_o <= cs_act & in_data & rd_frame;
         if (rd_load) begin
            tx_shift <= rd_word;
         end else if (sclk_fall && cs_act && in_data && rd_frame) begin
            spi_sio_o <= tx_shift[15];
            tx_shift  <= {tx_shift[14:0], 1'b0};
         end
      end
   end

   // Quarter-millisecond prescaler, realigned on soft reset and measurement start
   always_ff @(posedge core_clk_i) begin
      if (srst_i || soft_start || meas_start) pre_cnt <= 20'h00000;
      else if (unit_tick)                     pre_cnt <= 20'h00000;
      else                                    pre_cnt <= pre_cnt + 20'h00001;
   end
   assign unit_tick = (pre_cnt == 20'(UNIT_CYCLES - 1));

   // Soft reset: held for whole units after the write; the link itself stays alive
   assign soft_start = wr_cfg & rx_next[`TSAC_CFG_SRST_BIT];
   always_ff @(posedge core_clk_i) begin
      if (srst_i)                             soft_left <= 4'h0;
      else if (soft_start)                    soft_left <= 4'(SOFT_UNITS);
      else if (unit_tick && soft_left != 4'h0) soft_left <= soft_left - 4'h1;
   end
   assign soft_rst_busy_o = (soft_left != 4'h0);
   assign int_rst         = srst_i | soft_rst_busy_o;
   assign os_trig         = wr_cfg & ~soft_start & rx_next[`TSAC_CFG_ONESHOT_BIT];

   // Configuration register; a finished one-shot forces shutdown
   always_ff @(posedge core_clk_i) begin
      if (int_rst) begin
         cfg <= cfg_from_word(`TSAC_CFG_RESET);
      end else if (wr_cfg && !soft_start) begin
         cfg <= cfg_from_word(rx_next);
      end else if (res_done && oneshot_pend) begin
         cfg.shutdown <= 1'b1;
      end
   end

   // Sequencer decisions; a start also realigns the prescaler, so none may fire during soft reset
   assign period_up  = (unit_cnt >= period_units(cfg.period_sel));
   assign meas_start = !int_rst && (((seq == tsac_pkg::SEQ_SHUT) && (os_trig || !cfg.shutdown)) ||
                       ((seq == tsac_pkg::SEQ_WAIT) && (os_trig || (!cfg.shutdown && period_up))));

   // Averaging datapath: a truncating shift keeps the mean in the result format
   always_comb begin
      sum_next = acc + {{3{conv_data_i[13]}}, conv_data_i};
      res_val  = cfg.averaging_enable ? sum_next[16:`TSAC_AVG_SHIFT] : conv_data_i;
      res_done = (seq == tsac_pkg::SEQ_MEAS) && conv_done_i &&
                 (!cfg.averaging_enable || (samp_cnt == `TSAC_AVG_LAST));
   end

   // Conversion sequencer: shutdown, measuring, waiting out the period
   always_ff @(posedge core_clk_i) begin
      if (int_rst) begin
         seq          <= tsac_pkg::SEQ_SHUT;
         conv_start_o <= 1'b0;
         oneshot_pend <= 1'b0;
         samp_cnt     <= 3'h0;
         acc          <= 17'h00000;
         unit_cnt     <= 13'h0000;
      end else begin
         conv_start_o <= meas_start || ((seq == tsac_pkg::SEQ_MEAS) && conv_done_i && !res_done);
         if (os_trig) oneshot_pend <= 1'b1;
         if (meas_start) begin
            unit_cnt <= 13'h0000;
            samp_cnt <= 3'h0;
            acc      <= 17'h00000;
         end else if (unit_tick && unit_cnt != 13'h1FFF) begin
            unit_cnt <= unit_cnt + 13'h0001;
         end
         unique case (seq)
            tsac_pkg::SEQ_SHUT: if (meas_start) seq <= tsac_pkg::SEQ_MEAS;
            tsac_pkg::SEQ_MEAS: begin
               if (conv_done_i) begin
                  samp_cnt <= samp_cnt + 3'h1;
                  acc      <= sum_next;
               end
               if (res_done) begin
                  oneshot_pend <= os_trig;
                  seq <= (oneshot_pend || cfg.shutdown) ? tsac_pkg::SEQ_SHUT : tsac_pkg::SEQ_WAIT;
               end
            end
            tsac_pkg::SEQ_WAIT: begin
               if (meas_start)        seq <= tsac_pkg::SEQ_MEAS;
               else if (cfg.shutdown) seq <= tsac_pkg::SEQ_SHUT;
            end
         endcase
      end
   end

   // Threshold arithmetic, widened so hysteresis cannot wrap
   always_comb begin
      r_s       = {{3{res_val[13]}}, res_val};
      hi_s      = {{3{limits_i.high[13]}}, limits_i.high};
      lo_s      = {{3{limits_i.low[13]}}, limits_i.low};
      hi_rel_s  = hi_s - $signed({5'h00, limits_i.high_hyst, 4'h0});
      lo_rel_s  = lo_s + $signed({5'h00, limits_i.low_hyst, 4'h0});
      lim_valid = (hi_s > lo_s);
      next_hi_state = hi_state;
      next_lo_state = lo_state;
      if (!hi_state && (r_s > hi_s))    next_hi_state = 1'b1;
      if (hi_state && (r_s < hi_rel_s)) next_hi_state = 1'b0;
      if (!lo_state && (r_s < lo_s))    next_lo_state = 1'b1;
      if (lo_state && (r_s > lo_rel_s)) next_lo_state = 1'b0;
   end

   // Result and limit states move only when a result completes
   always_ff @(posedge core_clk_i) begin
      if (int_rst) begin
         temp_val <= 14'h0000;
         hi_state <= 1'b0;
         lo_state <= 1'b0;
      end else if (res_done) begin
         temp_val <= res_val;
         hi_state <= lim_valid & next_hi_state;
         lo_state <= lim_valid & next_lo_state;
      end
   end

   // Sticky flags: each state transition with valid limits sets its flag; set wins over a read clear
   always_ff @(posedge core_clk_i) begin
      if (int_rst) begin
         hi_flag  <= 1'b0;
         lo_flag  <= 1'b0;
         rdy_flag <= 1'b0;
      end else begin
         if (res_done && lim_valid && (next_hi_state != hi_state)) hi_flag <= 1'b1;
         else if (clr_flags)                                       hi_flag <= 1'b0;
         if (res_done && lim_valid && (next_lo_state != lo_state)) lo_flag <= 1'b1;
         else if (clr_flags)                                       lo_flag <= 1'b0;
         if (res_done)       rdy_flag <= 1'b1;
         else if (clr_ready) rdy_flag <= 1'b0;
      end
   end

   // Alert pin level: latched flags in interrupt mode, live limit states and the latched ready flag in comparator mode
   always_ff @(posedge core_clk_i) begin
      if (int_rst) begin
         alert_o <= 1'b0;
      end else if (cfg.comp_mode) begin
         alert_o <= (hi_state & alert_en_i.high) | (lo_state & alert_en_i.low) |
                    (rdy_flag & alert_en_i.ready);
      end else begin
         alert_o <= (hi_flag & alert_en_i.high) | (lo_flag & alert_en_i.low) |
                    (rdy_flag & alert_en_i.ready);
      end
   end

endmodule : tsac_core

// ==== logic/tsac_defs.svh ====
// Constants of the temperature sensor alert and configuration block.
// Assumes inclusion by bare name from every file that needs an offset, a field or a count.
`ifndef TSAC_DEFS_SVH
`define TSAC_DEFS_SVH

// Register offsets on the serial link
`define TSAC_ADDR_TEMP        8'h00
`define TSAC_ADDR_FLAGS       8'h02
`define TSAC_ADDR_CFG         8'h03

// Configuration word fields and reset value
`define TSAC_CFG_RESET        16'h0006
`define TSAC_CFG_SRST_BIT     8
`define TSAC_CFG_AVG_BIT      7
`define TSAC_CFG_COMP_BIT     5
`define TSAC_CFG_ONESHOT_BIT  4
`define TSAC_CFG_MODE_BIT     3
`define TSAC_CFG_PER_MSB      2
`define TSAC_CFG_PER_LSB      0

// Alert flags word fields
`define TSAC_FLAG_HI_ST_BIT   4
`define TSAC_FLAG_LO_ST_BIT   3
`define TSAC_FLAG_HI_BIT      2
`define TSAC_FLAG_LO_BIT      1
`define TSAC_FLAG_RDY_BIT     0

// Temperature word: 14-bit result above two zero bits
`define TSAC_TEMP_LSB         2

// Command word fields of a link frame
`define TSAC_CMD_INC_BIT      9
`define TSAC_CMD_READ_BIT     8

// Arithmetic scaling: hysteresis LSB is sixteen result LSBs, eight samples averaged
`define TSAC_HYST_SHIFT       4
`define TSAC_AVG_SHIFT        3
`define TSAC_AVG_LAST         3'h7

// Timing
`define TSAC_CLK_HZ           125000000
`define TSAC_UNIT_TIME_US     250
`define TSAC_SOFT_RST_TIME_US 500
`define TSAC_PER0_US          6000
`define TSAC_PER1_US          31250
`define TSAC_PER2_US          62500
`define TSAC_PER3_US          125000
`define TSAC_PER4_US          250000
`define TSAC_PER5_US          500000
`define TSAC_PER6_US          1000000
`define TSAC_PER7_US          2000000

`endif

// ==== logic/tsac_pkg.sv ====
// Types shared by the temperature sensor alert and configuration block.
// Assumes nothing of its surroundings; holds no constants, those live in the defs header.
package tsac_pkg;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      SEQ_SHUT,
      SEQ_MEAS,
      SEQ_WAIT
   } tsac_seq_e;

   // Stored configuration fields
   typedef struct packed {
      logic       averaging_enable;
      logic       comp_mode;
      logic       shutdown;
      logic [2:0] period_sel;
   } tsac_cfg_s;

   // Thresholds in result LSBs, hysteresis in half-degree steps
   typedef struct packed {
      logic signed [13:0] high;
      logic signed [13:0] low;
      logic        [7:0]  high_hyst;
      logic        [7:0]  low_hyst;
   } tsac_limits_s;

   // Which events may drive the alert pin
   typedef struct packed {
      logic high;
      logic low;
      logic ready;
   } tsac_alert_en_s;

endpackage : tsac_pkg

// ==== logic/tsac_sync2.sv ====
// Two-flop synchroniser for pins that arrive from outside the core clock.
// Assumes each bit is an independent level; the reset value matches the idle pin level.
`timescale 1ns/1ps
module tsac_sync2 #(
   parameter int unsigned     WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             core_clk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // First stage is read only by the second stage
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         meta   <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule : tsac_sync2

// ==== testbench/tsac_core_bench.sv ====
// Self-checking bench for the sensor alert and configuration core.
// Assumes the host model in tsac_host.sv and the checker bound below.
`timescale 1ns/1ps
module tsac_core_bench;
   localparam int unsigned UNIT = 20;
   localparam int unsigned LIMIT = 80000;
   logic                   core_clk_i, srst_i, conv_done_i, sio_wire, last_wire, sio_o, sio_oe;
   logic                   h_clk, h_cs_n, h_d, h_oe, rd_done, alert_o, busy, conv_start_o;
   logic signed [13:0]     conv_data_i, conv_val;
   logic [15:0]            rd_word;
   logic [13:0]            vals[7] = '{14'h00C8, 14'h0096, 14'h005A, 14'h0032, 14'h3F38, 14'h3FA6, 14'h3FCE};
   logic [15:0]            fexp[7] = '{16'h0015, 16'h0011, 16'h0011, 16'h0005, 16'h000B, 16'h0009, 16'h0003};
   logic [15:0]            punits[3] = '{16'h0018, 16'h007D, 16'h00FA};
   tsac_pkg::tsac_limits_s limits_i;
   tsac_pkg::tsac_alert_en_s alert_en;
   logic [15:0]            exp_q[$];
   int                     failures, checks_done, cyc, dones, jit, lat, j, k, w, t0, t1;
   integer                 seed = 32'hE3925F1D;
   tsac_host host (.spi_clk_o(h_clk), .spi_cs_n_o(h_cs_n), .sio_d_o(h_d), .sio_oe_o(h_oe),
      .sio_i(sio_wire), .rd_word_o(rd_word), .rd_done_o(rd_done));
   tsac_core #(.UNIT_CYCLES(UNIT)) DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .spi_clk_i(h_clk),
      .spi_cs_n_i(h_cs_n), .spi_sio_i(sio_wire), .spi_sio_o(sio_o), .spi_sio_oe_o(sio_oe),
      .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
      .limits_i(limits_i), .alert_en_i(alert_en), .alert_o(alert_o), .soft_rst_busy_o(busy));
   // Released wire shows the inverse of its last level, so no stale bit passes
   assign sio_wire = sio_oe ? sio_o : (h_oe ? h_d : ~last_wire);
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   // Hang guard and last driven data level
   always @(posedge core_clk_i) begin
      cyc++;
      if (sio_oe || h_oe) last_wire <= sio_wire;
      if (cyc == LIMIT) begin
         failures++;
         complete_run();
      end
   end
   // Converter: answers each start after a random latency
   initial begin
      conv_done_i = 1'b0;
      conv_data_i = 14'h0000;
      forever begin
         if (conv_start_o === 1'b1) begin
            lat = 2 + ($random(seed) & 7);
            repeat (lat) @(posedge core_clk_i);
            #1 conv_done_i = 1'b1;
            conv_data_i = conv_val + 14'(jit);
            jit++;
            @(posedge core_clk_i);
            #1 conv_done_i = 1'b0;
            dones++;
         end else begin
            @(posedge core_clk_i);
            #1;
         end
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Each finished read is matched with the oldest note
   always @(posedge rd_done) begin
      check("read word", rd_word, exp_q.pop_front());
   end
   task automatic rd(input logic [15:0] cmd, input logic [15:0] exp);
      exp_q.push_back(exp);
      host.xfer(cmd, 16'h0000, 1'b0 | 1'b1);
      @(posedge core_clk_i);
      #1;
   endtask : rd
   task automatic wr(input logic [15:0] d);
      host.xfer(16'h0003, d, 1'b0);
      repeat (8) @(posedge core_clk_i);
      #1;
   endtask : wr
   // Loads a result, writes the trigger and waits for n samples
   task automatic meas(input logic [13:0] v, input logic [15:0] cfg, input int n);
      int m, c;
      conv_val = v;
      jit = 0;
      m = dones + n;
      wr(cfg);
      for (c = 0; c < 3000 && dones < m; c++) @(posedge core_clk_i);
      repeat (4) @(posedge core_clk_i);
      #1;
   endtask : meas
   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      srst_i = 1'b1;
      conv_val = 14'h0000;
      last_wire = 1'b0;
      limits_i = '{high: 14'h0064, low: 14'h3F9C, high_hyst: 8'h01, low_hyst: 8'h01};
      alert_en = 3'h7;
      repeat (12) @(posedge core_clk_i);
      #1 srst_i = 1'b0;
      repeat (40) @(posedge core_clk_i);
      rd(16'h0103, 16'h0006);
      rd(16'h0102, 16'h0001);
      rd(16'h0100, 16'h0000);
      rd(16'h0102, 16'h0000);
      wr(16'hFE68);
      rd(16'h0103, 16'h0028);
      $display("test reset and setup done");
      for (j = 0; j < 7; j++) begin
         meas(vals[j], 16'h0018, 1);
         rd(16'h0102, fexp[j]);
      end
      meas(14'h00C8, 16'h0010, 1);
      check("alert", {15'h0, alert_o}, 16'h0001);
      rd(16'h0103, 16'h0008);
      rd(16'h0302, 16'h0015);
      rd(16'h0102, 16'h0015);
      rd(16'h0102, 16'h0010);
      check("alert", {15'h0, alert_o}, 16'h0000);
      wr(16'h0028);
      check("alert", {15'h0, alert_o}, 16'h0001);
      // High enable off: the live high state alone must no longer drive the pin
      alert_en = 3'h3;
      repeat (3) @(posedge core_clk_i);
      #1;
      check("alert", {15'h0, alert_o}, 16'h0000);
      $display("test limit flags done");
      meas(14'h0028, 16'h0098, 8);
      rd(16'h0100, 16'h00AC);
      rd(16'h0102, 16'h0004);
      $display("test averaging done");
      for (j = 0; j < 3; j++) begin
         wr(16'(j));
         for (k = 0; k < 3; k++) begin
            for (w = 0; w < 12000 && conv_start_o !== 1'b1; w++) @(posedge core_clk_i) #1;
            t0 = t1;
            t1 = cyc;
            @(posedge core_clk_i) #1;
         end
         check("period units", 16'((t1 - t0 + UNIT / 2) / UNIT), punits[j]);
      end
      $display("test periods done");
      wr(16'h0108);
      for (w = 0; w < 500 && busy !== 1'b0; w++) @(posedge core_clk_i) #1;
      rd(16'h0103, 16'h0006);
      $display("test soft reset done");
      complete_run();
   end
endmodule : tsac_core_bench
bind tsac_core tsac_core_checker #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
   .spi_clk_i(spi_clk_i), .spi_cs_n_i(spi_cs_n_i), .spi_sio_o(spi_sio_o), .spi_sio_oe_o(spi_sio_oe_o),
   .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .alert_o(alert_o), .soft_rst_busy_o(soft_rst_busy_o));

// ==== testbench/tsac_core_checker.sv ====
// Port-level checks for the sensor alert and configuration core.
// Assumes a bind into tsac_core with its UNIT_CYCLES handed on.
`timescale 1ns/1ps
module tsac_core_checker #(
   parameter int unsigned UNIT_CYCLES = 31250
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sio_o,
   input wire logic spi_sio_oe_o,
   input wire logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic alert_o,
   input wire logic soft_rst_busy_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   logic [31:0] busy_len;
   // Length of the running soft reset; a counter, as a repetition would not unroll
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !soft_rst_busy_o) begin
         busy_len <= 32'h0;
      end else begin
         busy_len <= busy_len + 32'h1;
      end
   end
   chk_start_pulse: assert property (conv_start_o |=> !conv_start_o)
      else $error("conversion start longer than one cycle");
   chk_start_after_rst: assert property ($fell(srst_i) |-> ##[1:3] conv_start_o)
      else $error("no conversion after reset in continuous mode");
   chk_reset_quiet: assert property ($fell(srst_i) |-> !alert_o && !spi_sio_oe_o && !soft_rst_busy_o)
      else $error("outputs active right after reset");
   chk_busy_len: assert property ($fell(soft_rst_busy_o) |-> busy_len == 2 * UNIT_CYCLES)
      else $error("soft reset length wrong");
   chk_busy_bound: assert property (busy_len <= 2 * UNIT_CYCLES)
      else $error("soft reset too long");
   chk_busy_no_start: assert property (soft_rst_busy_o |-> !conv_start_o)
      else $error("conversion started during soft reset");
   chk_oe_idle: assert property (spi_cs_n_i [*5] |-> !spi_sio_oe_o)
      else $error("data wire driven while deselected");
   chk_sio_stable: assert property ((spi_sio_oe_o && spi_clk_i) [*3] |-> $stable(spi_sio_o))
      else $error("read data moved while link clock high");
   chk_alert_cause: assert property ($rose(alert_o) |->
      $past(conv_done_i, 2) || $past(conv_done_i, 3) || !spi_cs_n_i || !$past(spi_cs_n_i, 4))
      else $error("alert rose without result or access");
   cov_soft_rst: cover property ($rose(soft_rst_busy_o));
   cov_alert: cover property ($rose(alert_o));
   cov_read: cover property ($rose(spi_sio_oe_o));
endmodule : tsac_core_checker

// ==== testbench/tsac_host.sv ====
// Host side of the 3-wire link: drives clock, select and data, samples read data.
// Assumes the bench resolves the shared data wire from both enables.
`timescale 1ns/1ps
module tsac_host (
   output logic        spi_clk_o,
   output logic        spi_cs_n_o,
   output logic        sio_d_o,
   output logic        sio_oe_o,
   input  wire logic   sio_i,
   output logic [15:0] rd_word_o,
   output logic        rd_done_o
);
   // Idle link: clock parked low, select high, data released
   initial begin
      spi_clk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      sio_d_o = 1'b0;
      sio_oe_o = 1'b0;
      rd_word_o = 16'h0000;
      rd_done_o = 1'b0;
   end
   // One frame, command then one word; flag reads use the single form to clear
   task automatic xfer(input logic [15:0] cmd, input logic [15:0] wdat, input logic rd);
      logic [31:0] w;
      int i;
      w = {cmd, wdat};
      spi_cs_n_o = 1'b0;
      #64;
      for (i = 31; i >= 0; i--) begin
         sio_oe_o = !(rd && i < 16);
         sio_d_o = w[i];
         #32;
         if (i < 16) rd_word_o[i] = sio_i;
         spi_clk_o = 1'b1;
         #32 spi_clk_o = 1'b0;
      end
      #32 spi_cs_n_o = 1'b1;
      sio_oe_o = 1'b0;
      #64 rd_done_o = rd;
      #1 rd_done_o = 1'b0;
   endtask : xfer
endmodule : tsac_host
